// ==== verilog/cip_pkg.sv ====
// Package for the capture interrupt priority register slice.
// Assumes a single AHB-Lite master and one clock domain.
// Overview of operation
// - Channel 5 bits 14-12, channel 4 bits 10-8.
// - Channel 3 priority field at bits 6-4.
// - Code 111 means level 7, highest.
// - 001 is level 1; 000 disables source.
// - Unimplemented bits ignore writes, read zero.
`default_nettype none
package cip_pkg;

   // ***************************************************************
   // Register map and field layout.
   // ***************************************************************
   localparam logic [11:0] CIP_PRIO_OFFSET = 12'h000;   // Byte offset of the register.
   localparam logic [11:0] CIP_LEVEL_OFFSET = 12'h004;  // Byte offset of enable readback.
   localparam int          CIP_CH5_LSB     = 12;        // Channel 5 field low bit.
   localparam int          CIP_CH4_LSB     = 8;         // Channel 4 field low bit.
   localparam int          CIP_CH3_LSB     = 4;         // Channel 3 field low bit.
   localparam logic [15:0] CIP_IMPL_MASK   = 16'h7770;  // Implemented bits.
   localparam logic [2:0]  CIP_PRIO_RESET  = 3'h4;      // Reset level of each field.
   localparam logic [15:0] CIP_REG_RESET   = 16'h4440;  // Whole register after reset.

   // Three priority fields travel together.
   typedef struct packed {
      logic [2:0] ch5;  // Channel 5 priority.
      logic [2:0] ch4;  // Channel 4 priority.
      logic [2:0] ch3;  // Channel 3 priority.
   } cip_prio_t;

endpackage
`default_nettype wire

// ==== verilog/cip_capture_irq_priority_reg.sv ====
// Capture interrupt priority register with an AHB-Lite slave port.
// It holds the three capture channel priority fields and hands their
// levels and enables to the interrupt arbiter elsewhere in the controller.
// Assumes a single master, whole-word transfers and one clock.
// Assumes the arbiter treats a zero level as a disabled source.
`timescale 1ns/100ps
`default_nettype none
module cip_capture_irq_priority_reg (
   input  wire logic                mclk,
   input  wire logic                resetn,
   input  wire logic                hsel,
   input  wire logic [11:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic      [31:0]         hrdata,
   output logic                     hreadyout,
   output logic                     hresp,
   output cip_pkg::cip_prio_t       capPriority,
   output logic      [2:0]          capEnable
);
   import cip_pkg::*;

   // ***************************************************************
   // Bus address phase capture.
   // ***************************************************************
   logic        wrPend_q, wrPend_d;   // Write data phase pending.
   logic [11:0] addr_q, addr_d;       // Captured address.
   cip_prio_t   prio_q, prio_d;       // The three priority fields.
   logic [31:0] rdata_q, rdata_d;     // Registered read data.
   logic        accept;               // Valid address phase this cycle.
   logic [2:0]  enable_q, enable_d;   // Registered source enables, ch5 down to ch3.

   // The bus is pipelined: a read address phase may sit in the same cycle
   // as the data phase of the write just before it.  The read image is
   // therefore built from the next field values, so software always sees
   // the word that it has just written and never a stale copy.

   // The slave never stalls, so hreadyout stays high and responses are OKAY.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_q;
   assign accept    = hsel && hready && htrans[1];

   // Packs fields into the 16-bit image; unimplemented bits are zero.
   function automatic logic [15:0] packReg(input cip_prio_t p);
      logic [15:0] r;
      r = 16'h0000;
      r[CIP_CH5_LSB +: 3] = p.ch5;
      r[CIP_CH4_LSB +: 3] = p.ch4;
      r[CIP_CH3_LSB +: 3] = p.ch3;
      return r & CIP_IMPL_MASK;
   endfunction

   // Next-state logic: writes land in the data phase, reads are answered
   // from the address phase so data is ready at the data phase.
   always_comb begin
      wrPend_d = accept && hwrite;
      addr_d   = accept ? haddr : addr_q;
      prio_d   = prio_q;
      rdata_d  = rdata_q;
      if (wrPend_q && addr_q == CIP_PRIO_OFFSET) begin
         // Only implemented bits are stored; the rest are dropped.
         prio_d.ch5 = hwdata[CIP_CH5_LSB +: 3];
         prio_d.ch4 = hwdata[CIP_CH4_LSB +: 3];
         prio_d.ch3 = hwdata[CIP_CH3_LSB +: 3];
      end
      // A source is enabled whenever its code is not zero.
      enable_d = {prio_d.ch5 != 3'h0, prio_d.ch4 != 3'h0,
                  prio_d.ch3 != 3'h0};
      if (accept && !hwrite) begin
         if (haddr == CIP_PRIO_OFFSET) begin
            // Forwarded image, so a write just before is already seen.
            rdata_d = {16'h0000, packReg(prio_d)};
         end else if (haddr == CIP_LEVEL_OFFSET) begin
            // Read-only enable readback; writes here are dropped.
            rdata_d = {29'h0, enable_d};
         end else begin
            // Unmapped addresses read as zero.
            rdata_d = 32'h0000_0000;
         end
      end
   end

   // Registers only; reset gives level 4 to every channel.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wrPend_q <= 1'b0;
         addr_q   <= 12'h000;
         prio_q   <= '{CIP_PRIO_RESET, CIP_PRIO_RESET, CIP_PRIO_RESET};
         rdata_q  <= 32'h0000_0000;
         // Every field resets to a non-zero level, so all sources are on.
         enable_q <= {3{CIP_PRIO_RESET != 3'h0}};
      end else begin
         wrPend_q <= wrPend_d;
         addr_q   <= addr_d;
         prio_q   <= prio_d;
         rdata_q  <= rdata_d;
         enable_q <= enable_d;
      end
   end

   // ***************************************************************
   // Level outputs to the arbiter.
   // ***************************************************************
   // The code is the level itself, 1 lowest to 7 highest; zero disables.
   assign capPriority = prio_q;
   // The enables come from flip-flops so the arbiter sees no decode glitch;
   // they update on the same edge as the fields that they follow.
   assign capEnable   = enable_q;

   // ***************************************************************
   // Assertions.
   // ***************************************************************
   // A priority write takes two steps: the address phase is taken at one
   // edge, and the data phase carries the word to the next edge.
   sequence s_prio_wr_addr;
      accept && hwrite && haddr == CIP_PRIO_OFFSET;
   endsequence

   // The address phase followed by the cycle of its data phase.
   sequence s_prio_wr_data;
      s_prio_wr_addr ##1 1'b1;
   endsequence

   // A read of the priority register, taken at its address phase.
   sequence s_prio_rd_addr;
      accept && !hwrite && haddr == CIP_PRIO_OFFSET;
   endsequence

   // A read of an address that no register decodes.
   sequence s_void_rd_addr;
      accept && !hwrite && haddr != CIP_PRIO_OFFSET && haddr != CIP_LEVEL_OFFSET;
   endsequence

   // The upper two fields take the word of the data phase.
   a_write_lands: assert property (@(posedge mclk) disable iff (!resetn)
      s_prio_wr_data |=>
      capPriority.ch5 == $past(hwdata[CIP_CH5_LSB +: 3]) &&
      capPriority.ch4 == $past(hwdata[CIP_CH4_LSB +: 3]))
      else $error("priority write not stored");

   // The channel 3 field takes its bits of the same word.
   a_ch3_lands: assert property (@(posedge mclk) disable iff (!resetn)
      s_prio_wr_data |=>
      capPriority.ch3 == $past(hwdata[CIP_CH3_LSB +: 3]))
      else $error("channel 3 write not stored");

   // With no write in flight, a read shows each field in its own place.
   a_read_image: assert property (@(posedge mclk) disable iff (!resetn)
      (s_prio_rd_addr ##0 !wrPend_q) |=>
      hrdata[15:0] == {1'b0, $past(capPriority.ch5), 1'b0, $past(capPriority.ch4),
                       1'b0, $past(capPriority.ch3), 4'h0})
      else $error("read image wrong");

   // A channel 5 field at the highest code is an enabled source.
   a_top_level: assert property (@(posedge mclk) disable iff (!resetn)
      capPriority.ch5 == 3'h7 |-> capEnable[2])
      else $error("level 7 not enabled");

   // The channel 5 field keeps the highest code as written, not clipped to a lower level.
   a_top_code_kept: assert property (@(posedge mclk) disable iff (!resetn)
      (s_prio_wr_data ##0 hwdata[CIP_CH5_LSB +: 3] == 3'h7) |=> capPriority.ch5 == 3'h7)
      else $error("level 7 not kept");

   // Code zero, and only code zero, turns a source off.
   a_zero_disables: assert property (@(posedge mclk) disable iff (!resetn)
      capEnable[0] == (capPriority.ch3 != 3'h0))
      else $error("disable code mismatch");

   a_ch4_disable: assert property (@(posedge mclk) disable iff (!resetn)
      capEnable[1] == (capPriority.ch4 != 3'h0))
      else $error("channel 4 disable mismatch");

   a_ch5_disable: assert property (@(posedge mclk) disable iff (!resetn)
      capEnable[2] == (capPriority.ch5 != 3'h0))
      else $error("channel 5 disable mismatch");

   // Bits outside the three fields read as zero in a priority register read.
   a_unimpl_zero: assert property (@(posedge mclk) disable iff (!resetn)
      s_prio_rd_addr |=> (hrdata & ~{16'h0000, CIP_IMPL_MASK}) == 32'h0)
      else $error("unimplemented bits not zero");

   // An undecoded address returns an all-zero word.
   a_unmapped_zero: assert property (@(posedge mclk) disable iff (!resetn)
      s_void_rd_addr |=> hrdata == 32'h0)
      else $error("unmapped read not zero");

   // Right after reset the register image is the documented reset word.
   a_reset_value: assert property (@(posedge mclk)
      $rose(resetn) |-> packReg(prio_q) == CIP_REG_RESET)
      else $error("reset value wrong");

   // Right after reset every source is enabled.
   a_reset_enables: assert property (@(posedge mclk)
      $rose(resetn) |-> capEnable == {3{CIP_PRIO_RESET != 3'h0}})
      else $error("reset enables wrong");
endmodule // cip_capture_irq_priority_reg
`default_nettype wire

// ==== dv/cip_capture_irq_priority_reg_tb_top.sv ====
// Self-checking bench for the capture interrupt priority register.
// Assumes the design package and a single AHB-Lite master on mclk.
`timescale 1ns/100ps
`default_nettype none
module cip_capture_irq_priority_reg_tb_top;
   import cip_pkg::*;
   // ******************************************
   // Bench signals, notes queue and counters.
   // ******************************************
   logic mclk = 0, resetn = 0, hwrite = 0, rdPhase = 0, hsel = 1;
   logic [11:0] haddr = '0;
   logic [1:0]  htrans = '0;
   logic [31:0] hwdata = '0, hrdata, expV, w;
   logic        hreadyout, hresp;
   cip_prio_t   capPriority, f;
   logic [2:0]  capEnable, en;
   int          nMismatch = 0, samplesChecked = 0, seed = 32'h3a7e508c;
   logic [31:0] expQ[$];  // Expected read data, oldest first.
   always #50 mclk = ~mclk;  // A 10 MHz clock.
   cip_capture_irq_priority_reg i_dut (.mclk(mclk), .resetn(resetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .capPriority(capPriority), .capEnable(capEnable));
   task automatic check(input logic [31:0] got, input logic [31:0] want, input string s);
      samplesChecked++;
      if (got !== want) begin
         nMismatch++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, s, got, want);
      end
   endtask
   // One whole transfer; it waits for hready in both phases.
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      htrans <= 2'h2; haddr <= a; hwrite <= wr;
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      htrans <= 2'h0; hwdata <= d; rdPhase <= !wr;
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      rdPhase <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      expQ.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic give_verdict();
      $display("Counts: %0d checked, %0d mismatched", samplesChecked, nMismatch);
      if (nMismatch == 0 && samplesChecked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // The watcher takes the oldest note when read data is sampled.
   always @(posedge mclk) if (rdPhase && hreadyout === 1'b1) begin
      expV = expQ.pop_front();
      check(hrdata, expV, "read data");
      check(32'(hresp), 32'h0, "response");
   end
   initial begin
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      check(32'(capPriority), 32'h124, "reset fields");
      rd(CIP_PRIO_OFFSET, 32'h4440);
      $display("Test reset done");
      // Every code lands in every field; random junk fills the unused bits.
      for (int v = 0; v < 8; v++) begin
         f  = '{3'(v), 3'(v + 1), 3'(v + 2)};
         en = {f.ch5 != 3'h0, f.ch4 != 3'h0, f.ch3 != 3'h0};
         w  = {17'h0, f.ch5, 1'b0, f.ch4, 1'b0, f.ch3, 4'h0};
         bus(1'b1, CIP_PRIO_OFFSET, (32'($random(seed)) & ~32'h7770) | w);
         @(posedge mclk);
         check(32'(capPriority), 32'(f), "fields");
         check(32'(capEnable), 32'(en), "enables");
         rd(CIP_PRIO_OFFSET, w);
         rd(CIP_LEVEL_OFFSET, 32'(en));
      end
      $display("Test codes done");
      bus(1'b1, CIP_PRIO_OFFSET, 32'hffffffff);
      rd(CIP_PRIO_OFFSET, 32'h7770);
      bus(1'b1, 12'h008, 32'h0);
      rd(12'h008, 32'h0);
      rd(CIP_PRIO_OFFSET, 32'h7770);
      $display("Test unmapped done");
      // A transfer with the slave not selected must leave the fields alone.
      hsel <= 1'b0;
      bus(1'b1, CIP_PRIO_OFFSET, 32'h0);
      hsel <= 1'b1;
      rd(CIP_PRIO_OFFSET, 32'h7770);
      $display("Test deselect done");
      // A second reset in mid-run brings every field back to level 4.
      resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      check(32'(capPriority), 32'h124, "fields after reset");
      rd(CIP_PRIO_OFFSET, 32'h4440);
      $display("Test second reset done");
      @(posedge mclk);
      give_verdict();
   end
   initial begin
      #200000;
      nMismatch++;
      $display("CHECK FAILED at %0t: timeout", $time);
      give_verdict();
   end
endmodule // cip_capture_irq_priority_reg_tb_top
`default_nettype wire
